// file: verilog/ebt_pkg.sv
// Constants, types and the register map of the emulator break and trace unit.
// Assumes one 40 MHz clock shared by the target core's cycle strobes and the bus.
// Function
// - Software breakpoint halts before execution, eight maximum.
// - Hardware breakpoint halts after execution, two maximum.
// - Hardware break uses two address channels plus trigger.
// - Trigger edge selectable, high means falling, pass count.
// - Address event: point, inside range, outside range.
// - Channels combined by AND, OR or sequence.
// - Enabled break sources together; any one halts.
// - Trace full source halts when centred or after capture ends.
// - Trace event has its own separate combination.
// - Before mode keeps last 32K cycles before halt.
// - Centred mode keeps 32K around the trace point.
// - After mode records 32K from the trace point.
// - Record holds address, data, accumulator in order.
// - Record flags: skip, interrupt, stack error.
// - Record holds four probe input levels.
// - Timeout mode halts on a repeat hit in time.
// - Run timer mode halts after time since start.
// - Hit timer mode halts after time since hit.
// - Timer counts 10us ticks or target cycles.
package ebt_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 10;
	localparam int AREG_W = 4;
	localparam int NUM_CH = 6;
	localparam int NUM_SWBP = 8;
	localparam int TRC_DEPTH = 32768;
	localparam int TRC_PTR_W = 15;
	localparam int REC_W = 34;
	localparam logic [15:0] TRC_FULL_CNT = 16'h8000;
	localparam logic [15:0] TRC_HALF_CNT = 16'h4000;
	localparam int CLK_HZ = 40000000;
	localparam int TICK_US = 10;
	localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
	localparam logic [8:0] TICK_LAST = 9'(TICK_CYC - 1);
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_BRK_EN = 8'h04;
	localparam logic [7:0] OFF_BRK_CMB = 8'h08;
	localparam logic [7:0] OFF_TRC_CMB = 8'h0C;
	localparam logic [7:0] OFF_TRC_CFG = 8'h10;
	localparam logic [7:0] OFF_TMR_CFG = 8'h14;
	localparam logic [7:0] OFF_TMR_LIM = 8'h18;
	localparam logic [7:0] OFF_TMR_CNT = 8'h1C;
	localparam logic [7:0] OFF_TRC_IDX = 8'h20;
	localparam logic [7:0] OFF_TRC_LO = 8'h24;
	localparam logic [7:0] OFF_TRC_HI = 8'h28;
	localparam logic [7:0] OFF_TRC_CNT = 8'h2C;
	localparam logic [1:0] SEL_CH = 2'h1;
	localparam logic [2:0] SEL_SWBP = 3'h4;
	// ==========================================================
	// Modes.
	typedef enum logic [1:0] {
		EBT_AM_POINT = 2'h0,
		EBT_AM_IN = 2'h1,
		EBT_AM_OUT = 2'h2,
		EBT_AM_EXT = 2'h3
	} ebt_amode_t;
	typedef enum logic [1:0] {
		EBT_CMB_AND = 2'h0,
		EBT_CMB_OR = 2'h1,
		EBT_CMB_SEQ = 2'h2
	} ebt_cmb_t;
	localparam logic [1:0] TRC_BEFORE_BREAK = 2'h0;
	localparam logic [1:0] TRC_ABOUT = 2'h1;
	localparam logic [1:0] TRC_AFTER = 2'h2;
	localparam logic [1:0] TRC_BEFORE_TRACE = 2'h3;
	localparam logic [1:0] TIMER_OFF = 2'h0;
	localparam logic [1:0] TIMER_TIMEOUT = 2'h1;
	localparam logic [1:0] TIMER_FROM_RUN = 2'h2;
	localparam logic [1:0] TIMER_FROM_HIT = 2'h3;

	function automatic logic [31:0] ebt_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] r;
		r = old_w;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = new_w[8*b +: 8];
			end
		end
		return r;
	endfunction : ebt_merge
endpackage : ebt_pkg

// file: verilog/ebt_evt_chan.sv
// One event channel: address compare or trigger edge, with a pass count.
// Assumes stb and ext_match are already gated by the run state.
`timescale 1ns/1ps
`default_nettype none
module ebt_evt_chan (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic arm,
	input wire logic stb,
	input wire logic [12:0] addr,
	input wire ebt_pkg::ebt_amode_t mode,
	input wire logic [12:0] lo,
	input wire logic [12:0] hi,
	input wire logic [7:0] pass,
	input wire logic ext_match,
	output logic hit,
	output logic level
);
	typedef struct packed {
		logic [7:0] cnt;
		logic level;
		logic hit;
	} ebt_chan_st_t;
	ebt_chan_st_t q, d;
	logic m;

	always_comb begin
		case (mode)
			ebt_pkg::EBT_AM_POINT: m = stb & (addr == lo);
			ebt_pkg::EBT_AM_IN: m = stb & (addr >= lo) & (addr <= hi);
			ebt_pkg::EBT_AM_OUT: m = stb & ((addr < lo) | (addr > hi));
			default: m = ext_match;
		endcase
		d = q;
		d.hit = 1'b0;
		if (arm) begin
			d.cnt = 8'h00;
			d.level = 1'b0;
		end else if (m && !q.level) begin
			if (q.cnt + 8'h01 >= pass) begin
				d.level = 1'b1;
				d.hit = 1'b1;
			end else begin
				d.cnt = q.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign hit = q.hit;
	assign level = q.level;
endmodule : ebt_evt_chan
`default_nettype wire

// file: verilog/ebt_evt_comb.sv
// Combines three channel events into one event pulse, once per run.
// Assumes arm pulses at each run start together with the channels.
`timescale 1ns/1ps
`default_nettype none
module ebt_evt_comb (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic arm,
	input wire logic [2:0] en,
	input wire logic [1:0] mode,
	input wire logic [5:0] order,
	input wire logic [2:0] hit,
	input wire logic [2:0] level,
	output logic fire
);
	typedef struct packed {
		logic [1:0] step;
		logic done;
		logic fire;
	} ebt_comb_st_t;
	ebt_comb_st_t q, d;
	logic [1:0] sel;

	always_comb begin
		case (q.step)
			2'h0: sel = order[1:0];
			2'h1: sel = order[3:2];
			default: sel = order[5:4];
		endcase
		d = q;
		d.fire = 1'b0;
		if (arm) begin
			d.step = 2'h0;
			d.done = 1'b0;
		end else if (!q.done && en != 3'h0) begin
			case (mode)
				ebt_pkg::EBT_CMB_AND: begin
					d.done = ((level & en) == en);
					d.fire = d.done;
				end
				ebt_pkg::EBT_CMB_OR: begin
					d.done = ((hit & en) != 3'h0);
					d.fire = d.done;
				end
				ebt_pkg::EBT_CMB_SEQ: begin
					// A step naming a disabled channel is skipped, not waited on.
					if (q.step == 2'h3) begin
						d.done = 1'b1;
						d.fire = 1'b1;
					end else if (sel == 2'h3 || !en[sel] || hit[sel]) begin
						d.step = q.step + 2'h1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign fire = q.fire;
endmodule : ebt_evt_comb
`default_nettype wire

// file: verilog/ebt_top.sv
// Break and trace unit: event channels, break sources, trace memory, break timer.
// Assumes the target core strobes cycles on clk; trigger and probes are raw pins.
`timescale 1ns/1ps
`default_nettype none
module ebt_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cyc_stb,
	input wire logic [12:0] cyc_addr,
	input wire logic [9:0] cyc_data,
	input wire logic [3:0] cyc_areg,
	input wire logic cyc_skip,
	input wire logic cyc_int,
	input wire logic cyc_stack_err,
	input wire logic fetch_stb,
	input wire logic [12:0] fetch_addr,
	input wire logic ext_trig,
	input wire logic probe_input_zero,
	input wire logic probe_input_one,
	input wire logic probe_input_two,
	input wire logic probe_input_three,
	output logic target_run,
	output logic target_halt
);
	typedef struct packed {
		logic aw_ok;
		logic [7:0] aw_a;
		logic w_ok;
		logic [31:0] w_d;
		logic [3:0] w_s;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic hard;
		logic [3:0] brk_en;
		logic [10:0] bcmb;
		logic [10:0] tcmb;
		logic [1:0] trc_mode;
		logic [1:0] tmr_mode;
		logic tmr_cyc;
		logic [31:0] tmr_lim;
		logic [5:0][15:0] ch_cfg;
		logic [5:0][31:0] ch_rng;
		logic [7:0][15:0] swbp;
		logic [14:0] trc_idx;
		logic run;
		logic halted;
		logic go;
		logic trig_s1;
		logic trig_s2;
		logic trig_s3;
		logic [3:0] prb_s1;
		logic [3:0] prb_s2;
		logic [8:0] tick_cnt;
		logic tick;
		logic [14:0] trc_wp;
		logic [15:0] trc_cnt;
		logic [15:0] trc_post;
		logic trc_on;
		logic trc_trig;
		logic trc_done;
		logic [31:0] tmr_cnt;
		logic tmr_run;
	} ebt_top_st_t;
	ebt_top_st_t q, d;

	logic [ebt_pkg::REC_W-1:0] trc_mem [ebt_pkg::TRC_DEPTH];
	logic [ebt_pkg::REC_W-1:0] trc_rd_q;
	logic [ebt_pkg::REC_W-1:0] rec;
	logic [5:0] ch_hit;
	logic [5:0] ch_lvl;
	logic [7:0] sw_m;
	logic trig_rise, trig_fall, brk_fire, trc_fire, sw_hit, bp_hit;
	logic stk_evt, full_evt, tstep, tmr_exp, halt_cause, wr_en, wr_go;
	logic [31:0] wd;
	logic [32:0] rd_w;
	logic [32:0] rd_a;

	// ==========================================================
	// Register read-back, shared by the read channel and write merging.
	function automatic logic [32:0] rd_fn(input logic [7:0] a, input ebt_top_st_t s,
		input logic [33:0] r);
		logic [32:0] v;
		v = {1'b0, 32'h0000_0000};
		if (a[7:6] == ebt_pkg::SEL_CH && a[5:3] < 3'h6) begin
			v[31:0] = a[2] ? s.ch_rng[a[5:3]] : {16'h0000, s.ch_cfg[a[5:3]]};
		end else if (a[7:5] == ebt_pkg::SEL_SWBP) begin
			v[31:0] = {16'h0000, s.swbp[a[4:2]]};
		end else begin
			case (a)
				ebt_pkg::OFF_CTRL: v[31:0] = {21'h000000, s.trc_done, s.halted, s.run,
					6'h00, s.hard, 1'b0};
				ebt_pkg::OFF_BRK_EN: v[31:0] = {28'h0000000, s.brk_en};
				ebt_pkg::OFF_BRK_CMB: v[31:0] = {21'h000000, s.bcmb};
				ebt_pkg::OFF_TRC_CMB: v[31:0] = {21'h000000, s.tcmb};
				ebt_pkg::OFF_TRC_CFG: v[31:0] = {30'h00000000, s.trc_mode};
				ebt_pkg::OFF_TMR_CFG: v[31:0] = {29'h00000000, s.tmr_cyc, s.tmr_mode};
				ebt_pkg::OFF_TMR_LIM: v[31:0] = s.tmr_lim;
				ebt_pkg::OFF_TMR_CNT: v[31:0] = s.tmr_cnt;
				ebt_pkg::OFF_TRC_IDX: v[31:0] = {17'h00000, s.trc_idx};
				ebt_pkg::OFF_TRC_LO: v[31:0] = r[31:0];
				ebt_pkg::OFF_TRC_HI: v[31:0] = {30'h00000000, r[33:32]};
				ebt_pkg::OFF_TRC_CNT: v[31:0] = {1'b0, s.trc_wp, s.trc_cnt};
				default: v[32] = 1'b1;
			endcase
		end
		return v;
	endfunction : rd_fn

	assign rd_w = rd_fn(q.aw_a, q, trc_rd_q);
	assign rd_a = rd_fn(s_axi_araddr, q, trc_rd_q);
	assign wd = ebt_pkg::ebt_merge(rd_w[31:0], q.w_d, q.w_s);
	assign wr_go = q.aw_ok & q.w_ok & (q.aw_a == ebt_pkg::OFF_CTRL) & wd[0];

	// ==========================================================
	// Event channels: 0..2 feed the break event, 3..5 the trace event.
	assign trig_rise = q.run & q.trig_s2 & ~q.trig_s3;
	assign trig_fall = q.run & ~q.trig_s2 & q.trig_s3;

	for (genvar i = 0; i < ebt_pkg::NUM_CH; i++) begin : g_ch
		localparam bit IS_TRIG = (i % 3 == 2);
		ebt_evt_chan u_chan (
			.clk(clk),
			.sys_rst(sys_rst),
			.arm(q.go),
			.stb(cyc_stb & q.run),
			.addr(cyc_addr),
			.mode(IS_TRIG ? ebt_pkg::EBT_AM_EXT : ebt_pkg::ebt_amode_t'(q.ch_cfg[i][1:0])),
			.lo(q.ch_rng[i][12:0]),
			.hi(q.ch_rng[i][28:16]),
			.pass(q.ch_cfg[i][15:8]),
			.ext_match(q.ch_cfg[i][2] ? trig_fall : trig_rise),
			.hit(ch_hit[i]),
			.level(ch_lvl[i])
		);
	end

	ebt_evt_comb u_brk_comb (
		.clk(clk),
		.sys_rst(sys_rst),
		.arm(q.go),
		.en(q.bcmb[4:2]),
		.mode(q.bcmb[1:0]),
		.order(q.bcmb[10:5]),
		.hit(ch_hit[2:0]),
		.level(ch_lvl[2:0]),
		.fire(brk_fire)
	);

	ebt_evt_comb u_trc_comb (
		.clk(clk),
		.sys_rst(sys_rst),
		.arm(q.go),
		.en(q.tcmb[4:2]),
		.mode(q.tcmb[1:0]),
		.order(q.tcmb[10:5]),
		.hit(ch_hit[5:3]),
		.level(ch_lvl[5:3]),
		.fire(trc_fire)
	);

	// ==========================================================
	// Break sources.
	for (genvar j = 0; j < ebt_pkg::NUM_SWBP; j++) begin : g_swbp
		assign sw_m[j] = q.swbp[j][15] & (q.swbp[j][12:0] == fetch_addr);
	end
	// The fetch address is announced before execution, so a soft hit stops ahead of it.
	assign sw_hit = fetch_stb & q.run & (|sw_m);
	assign bp_hit = q.hard ? brk_fire : sw_hit;
	assign stk_evt = q.run & cyc_stb & cyc_stack_err;
	assign full_evt = q.trc_on & q.trc_trig & (q.trc_post == 16'h0001) & wr_en;
	assign tstep = q.tmr_cyc ? (cyc_stb & q.run) : q.tick;
	assign tmr_exp = q.tmr_run & (((q.tmr_mode == ebt_pkg::TIMER_FROM_RUN
		|| q.tmr_mode == ebt_pkg::TIMER_FROM_HIT) && q.tmr_cnt >= q.tmr_lim)
		|| (q.tmr_mode == ebt_pkg::TIMER_TIMEOUT && bp_hit && q.tmr_cnt < q.tmr_lim));
	assign halt_cause = (q.brk_en[0] & bp_hit) | (q.brk_en[1] & stk_evt)
		| (q.brk_en[2] & trc_fire) | (q.brk_en[3] & full_evt) | tmr_exp;
	assign wr_en = q.run & cyc_stb & q.trc_on;
	assign rec = {q.prb_s2, cyc_stack_err, cyc_int, cyc_skip, cyc_areg, cyc_data,
		cyc_addr};

	// ==========================================================
	// Next state.
	always_comb begin
		d = q;
		d.go = 1'b0;
		d.tick = 1'b0;
		d.trig_s1 = ext_trig;
		d.trig_s2 = q.trig_s1;
		d.trig_s3 = q.trig_s2;
		d.prb_s1 = {probe_input_three, probe_input_two, probe_input_one, probe_input_zero};
		d.prb_s2 = q.prb_s1;
		if (q.tick_cnt == ebt_pkg::TICK_LAST) begin
			d.tick_cnt = 9'h000;
			d.tick = 1'b1;
		end else begin
			d.tick_cnt = q.tick_cnt + 9'h001;
		end
		if (q.tmr_run && tstep && q.tmr_cnt < q.tmr_lim) begin
			d.tmr_cnt = q.tmr_cnt + 32'h0000_0001;
		end
		if (bp_hit && q.tmr_mode == ebt_pkg::TIMER_TIMEOUT) begin
			d.tmr_run = 1'b1;
			d.tmr_cnt = 32'h0000_0000;
		end
		if (bp_hit && q.tmr_mode == ebt_pkg::TIMER_FROM_HIT && !q.tmr_run) begin
			d.tmr_run = 1'b1;
			d.tmr_cnt = 32'h0000_0000;
		end
		if (wr_en) begin
			d.trc_wp = q.trc_wp + 15'h0001;
			if (q.trc_cnt != ebt_pkg::TRC_FULL_CNT) begin
				d.trc_cnt = q.trc_cnt + 16'h0001;
			end
			if (q.trc_trig) begin
				d.trc_post = q.trc_post - 16'h0001;
				if (q.trc_post == 16'h0001) begin
					d.trc_on = 1'b0;
					d.trc_done = 1'b1;
				end
			end
		end
		if (q.run && trc_fire && !q.trc_trig) begin
			d.trc_trig = 1'b1;
			case (q.trc_mode)
				ebt_pkg::TRC_ABOUT: d.trc_post = ebt_pkg::TRC_HALF_CNT;
				ebt_pkg::TRC_AFTER: begin
					d.trc_on = 1'b1;
					d.trc_post = ebt_pkg::TRC_FULL_CNT;
				end
				ebt_pkg::TRC_BEFORE_TRACE: begin
					d.trc_on = 1'b0;
					d.trc_done = 1'b1;
				end
				default: d.trc_trig = 1'b0;
			endcase
		end
		// A halt freezes capture, leaving the last cycles before it in memory.
		if (q.run && halt_cause) begin
			d.run = 1'b0;
			d.halted = 1'b1;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (s_axi_awready && s_axi_awvalid) begin
			d.aw_ok = 1'b1;
			d.aw_a = s_axi_awaddr;
		end
		if (s_axi_wready && s_axi_wvalid) begin
			d.w_ok = 1'b1;
			d.w_d = s_axi_wdata;
			d.w_s = s_axi_wstrb;
		end
		if (q.aw_ok && q.w_ok) begin
			d.aw_ok = 1'b0;
			d.w_ok = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = rd_w[32] ? ebt_pkg::RESP_SLVERR : ebt_pkg::RESP_OKAY;
			if (q.aw_a[7:6] == ebt_pkg::SEL_CH && q.aw_a[5:3] < 3'h6) begin
				if (q.aw_a[2]) begin
					d.ch_rng[q.aw_a[5:3]] = wd;
				end else begin
					d.ch_cfg[q.aw_a[5:3]] = wd[15:0];
				end
			end else if (q.aw_a[7:5] == ebt_pkg::SEL_SWBP) begin
				d.swbp[q.aw_a[4:2]] = wd[15:0];
			end else begin
				case (q.aw_a)
					ebt_pkg::OFF_CTRL: begin
						d.hard = wd[1];
						if (wd[2] && q.run) begin
							d.run = 1'b0;
							d.halted = 1'b1;
						end
					end
					ebt_pkg::OFF_BRK_EN: d.brk_en = wd[3:0];
					ebt_pkg::OFF_BRK_CMB: d.bcmb = wd[10:0];
					ebt_pkg::OFF_TRC_CMB: d.tcmb = wd[10:0];
					ebt_pkg::OFF_TRC_CFG: d.trc_mode = wd[1:0];
					ebt_pkg::OFF_TMR_CFG: begin
						d.tmr_mode = wd[1:0];
						d.tmr_cyc = wd[2];
					end
					ebt_pkg::OFF_TMR_LIM: d.tmr_lim = wd;
					ebt_pkg::OFF_TRC_IDX: d.trc_idx = wd[14:0];
					default: begin
					end
				endcase
			end
		end
		// A start re-arms every channel, clears the trace and starts the run timer.
		if (wr_go) begin
			d.go = 1'b1;
			d.run = 1'b1;
			d.halted = 1'b0;
			d.trc_wp = 15'h0000;
			d.trc_cnt = 16'h0000;
			d.trc_post = 16'h0000;
			d.trc_trig = 1'b0;
			d.trc_done = 1'b0;
			d.trc_on = (q.trc_mode != ebt_pkg::TRC_AFTER);
			d.tmr_cnt = 32'h0000_0000;
			d.tmr_run = (q.tmr_mode == ebt_pkg::TIMER_FROM_RUN);
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arready && s_axi_arvalid) begin
			d.rvalid = 1'b1;
			d.rdata = rd_a[31:0];
			d.rresp = rd_a[32] ? ebt_pkg::RESP_SLVERR : ebt_pkg::RESP_OKAY;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Trace memory has no reset so that it maps onto block RAM.
	always_ff @(posedge clk) begin
		if (wr_en) begin
			trc_mem[q.trc_wp] <= rec;
		end
		trc_rd_q <= trc_mem[q.trc_idx];
	end

	assign s_axi_awready = ~q.aw_ok & ~q.bvalid;
	assign s_axi_wready = ~q.w_ok & ~q.bvalid;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = ~q.rvalid;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign target_run = q.run;
	assign target_halt = q.halted;

	// ==========================================================
	// Checks.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	AST_SW_BREAK: assert property (q.run && !q.hard && q.brk_en[0] && sw_hit && !wr_go
		|=> target_halt && !target_run) else $error("soft breakpoint did not halt");
	AST_HW_BREAK: assert property (q.run && q.hard && q.brk_en[0] && brk_fire && !wr_go
		|=> target_halt) else $error("hard breakpoint did not halt");
	AST_STACK: assert property (q.run && q.brk_en[1] && stk_evt && !wr_go
		|=> target_halt) else $error("stack error did not halt");
	AST_TRC_EVT: assert property (q.run && q.brk_en[2] && trc_fire && !wr_go
		|=> target_halt) else $error("trace event did not halt");
	AST_TRC_FULL: assert property (q.run && q.brk_en[3] && full_evt && !wr_go
		|=> target_halt && q.trc_done) else $error("trace full did not halt");
	AST_TMR_RUN: assert property (q.run && q.tmr_run && q.tmr_cnt >= q.tmr_lim
		&& q.tmr_mode == ebt_pkg::TIMER_FROM_RUN && !wr_go |=> !target_run)
		else $error("run timer did not halt");
	AST_TRC_AFTER: assert property (q.run && trc_fire && !q.trc_trig && !wr_go
		&& q.trc_mode == ebt_pkg::TRC_AFTER |=> q.trc_on && q.trc_post == 16'h8000)
		else $error("post trigger capture not started");
	AST_TRC_WP: assert property (wr_en && !wr_go |=> q.trc_wp == $past(q.trc_wp) + 15'h0001)
		else $error("trace pointer did not advance");
	AST_HALT_HOLD: assert property (target_halt && !wr_go |=> target_halt)
		else $error("halt released without a start");

	COV_SW_BREAK: cover property (sw_hit && q.brk_en[0] ##1 target_halt);
	COV_TRC_DONE: cover property (q.trc_on ##1 q.trc_done);
	COV_TMR_EXP: cover property (tmr_exp && q.run);
endmodule : ebt_top
`default_nettype wire

// file: tb/ebt_core_model.sv
// Target core model: one fetch, then one executed bus cycle, every six clocks.
// Assumes target_run and target_halt come from the break unit on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ebt_core_model (
	input wire logic clk,
	input wire logic target_run,
	input wire logic target_halt,
	output logic cyc_stb,
	output logic [12:0] cyc_addr,
	output logic [9:0] cyc_data,
	output logic [3:0] cyc_areg,
	output logic cyc_skip,
	output logic cyc_int,
	output logic cyc_stack_err,
	output logic fetch_stb,
	output logic [12:0] fetch_addr,
	output logic [12:0] last_addr,
	output logic [15:0] exec_cnt
);
	// Six clocks a cycle leave room for the slowest halt, a sequence with a skipped step.
	logic [2:0] ph = 3'h0;
	logic [12:0] pc = 13'h0;
	logic act_q = 1'b0;
	logic act;
	assign act = target_run && !target_halt;
	initial begin
		{cyc_stb, cyc_addr, cyc_data, cyc_areg, cyc_skip, cyc_int, cyc_stack_err} = '0;
		{fetch_stb, fetch_addr, last_addr, exec_cnt} = '0;
	end
	// ==========================================
	// Idle address and data buses toggle so a stale value is never mistaken for a live one; cyc_areg holds.
	always @(posedge clk) begin
		act_q <= act;
		cyc_stb <= 1'b0;
		fetch_stb <= 1'b0;
		cyc_addr <= ~cyc_addr;
		cyc_data <= ~cyc_data;
		fetch_addr <= ~fetch_addr;
		if (act && !act_q) begin
			pc <= 13'h0;
			ph <= 3'h0;
			exec_cnt <= 16'h0;
		end else if (act) begin
			ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
			if (ph == 3'h0) begin
				fetch_stb <= 1'b1;
				fetch_addr <= pc;
			end
			if (ph == 3'h5) begin
				cyc_stb <= 1'b1;
				cyc_addr <= pc;
				cyc_data <= pc[9:0] ^ 10'h2A5;
				cyc_areg <= pc[3:0];
				{cyc_stack_err, cyc_int, cyc_skip} <= pc[2:0];
				last_addr <= pc;
				exec_cnt <= exec_cnt + 16'h1;
				pc <= pc + 13'h1;
			end
		end
	end
endmodule : ebt_core_model
`default_nettype wire

// file: tb/tb_ebt_top.sv
// Self-checking bench: AXI4-Lite master, core model, read scoreboard.
// Assumes a 40 MHz clock; the trigger pin is driven here and probe pins held fixed.
`timescale 1ns/1ps
`default_nettype none
module tb_ebt_top;
	typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} ebt_exp_t;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_val;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic cyc_stb, cyc_skip, cyc_int, cyc_stack_err, fetch_stb, target_run, target_halt;
	logic [12:0] cyc_addr, fetch_addr, last_addr, bp;
	logic [9:0] cyc_data;
	logic [3:0] cyc_areg;
	logic [3:0] probes = 4'hA;
	logic trig = 1'b0;
	logic [15:0] exec_cnt;
	logic [14:0] idx;
	logic [33:0] r;
	int num_errors = 0, total_checks = 0, seed = 37;
	ebt_exp_t exp_q[$];
	always #12.5 clk = ~clk;
	ebt_top DUT (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .cyc_stb(cyc_stb), .cyc_addr(cyc_addr), .cyc_data(cyc_data),
		.cyc_areg(cyc_areg), .cyc_skip(cyc_skip), .cyc_int(cyc_int),
		.cyc_stack_err(cyc_stack_err), .fetch_stb(fetch_stb), .fetch_addr(fetch_addr),
		.ext_trig(trig), .probe_input_zero(probes[0]), .probe_input_one(probes[1]),
		.probe_input_two(probes[2]), .probe_input_three(probes[3]),
		.target_run(target_run), .target_halt(target_halt));
	ebt_core_model core (.clk(clk), .target_run(target_run), .target_halt(target_halt),
		.cyc_stb(cyc_stb), .cyc_addr(cyc_addr), .cyc_data(cyc_data), .cyc_areg(cyc_areg),
		.cyc_skip(cyc_skip), .cyc_int(cyc_int), .cyc_stack_err(cyc_stack_err),
		.fetch_stb(fetch_stb), .fetch_addr(fetch_addr), .last_addr(last_addr),
		.exec_cnt(exec_cnt));
	// ==========================================
	// Tasks.
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (s_axi_awready === 1'b1 && !aw) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1 && !w) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		@(posedge clk);
	endtask : wr
	// The queue note is made before the address goes out; the monitor pops it.
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [1:0] er);
		exp_q.push_back('{d, m, er});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		rd_val = s_axi_rdata;
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask : rd
	always @(posedge clk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			chk("rdata", exp_q[0].d & exp_q[0].m, s_axi_rdata & exp_q[0].m);
			chk("rresp", {30'h0, exp_q[0].r}, {30'h0, s_axi_rresp});
			void'(exp_q.pop_front());
		end
	end
	task automatic go(input logic [31:0] ctrl);
		int n;
		wr(8'h00, ctrl, 2'h0);
		n = 0;
		while (target_halt !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk("halt", 32'h1, 32'(target_halt));
		chk("run", 32'h0, 32'(target_run));
	endtask : go
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done
	initial begin
		#(25 * 40000);
		num_errors++;
		test_done();
	end
	// ==========================================
	// Scenarios.
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		rd(8'h00, 32'h0, 32'hFFFFFFFF, 2'h0);
		rd(8'h3C, 32'h0, 32'hFFFFFFFF, 2'h2);
		wr(8'h3C, 32'h1, 2'h2);
		bp = 13'd16 + 13'($random(seed) & 15);
		for (int i = 0; i < 8; i++) begin
			wr(8'h80 + 8'(4 * i), 32'h8000 | 32'(bp) + 32'(8 * (7 - i)), 2'h0);
		end
		wr(8'h04, 32'h1, 2'h0);
		go(32'h1);
		chk("soft_stop", 32'(bp - 13'h1), 32'(last_addr));
		rd(8'h00, 32'h200, 32'h300, 2'h0);
		// Point, inside-range with three passes, outside-range.
		for (int k = 0; k < 3; k++) begin
			wr(8'h40, (k == 0) ? 32'h0 : (k == 1) ? 32'h301 : 32'h2, 2'h0);
			wr(8'h44, (k == 0) ? 32'(bp) : (k == 1) ? 32'h1E0014 : 32'h280005, 2'h0);
			wr(8'h08, 32'h5, 2'h0);
			go(32'h3);
			chk("hard_stop", (k == 0) ? 32'(bp) : (k == 1) ? 32'd22 : 32'd0, 32'(last_addr));
		end
		wr(8'h40, 32'h0, 2'h0);
		wr(8'h44, 32'd10, 2'h0);
		wr(8'h48, 32'h0, 2'h0);
		wr(8'h4C, 32'd14, 2'h0);
		// AND, OR, then sequence: first channel, second channel, last step skipped.
		for (int m = 0; m < 3; m++) begin
			wr(8'h08, (m == 2) ? 32'h68E : 32'hC | 32'(m), 2'h0);
			go(32'h3);
			chk("combine", (m == 1) ? 32'd10 : 32'd14, 32'(last_addr));
		end
		wr(8'h04, 32'h0, 2'h0);
		wr(8'h18, 32'd20, 2'h0);
		wr(8'h14, 32'h6, 2'h0);
		go(32'h3);
		chk("run_timer", 32'h1, 32'(exec_cnt >= 16'd19 && exec_cnt <= 16'd21));
		wr(8'h14, 32'h0, 2'h0);
		rd(8'h2C, 32'h0, 32'h0, 2'h0);
		idx = rd_val[30:16] - rd_val[14:0];
		chk("trace_count", 32'(exec_cnt), {16'h0000, rd_val[15:0]});
		for (int k = 0; k < 2; k++) begin
			r = {probes, 3'(k), 4'(k), 10'(k) ^ 10'h2A5, 13'(k)};
			wr(8'h20, 32'(idx + 15'(k)), 2'h0);
			repeat (2) @(posedge clk);
			rd(8'h24, r[31:0], 32'hFFFFFFFF, 2'h0);
			rd(8'h28, 32'(r[33:32]), 32'h3, 2'h0);
		end
		// In falling mode a rising trigger edge is ignored; the falling edge breaks.
		wr(8'h04, 32'h1, 2'h0);
		wr(8'h50, 32'h4, 2'h0);
		wr(8'h08, 32'h11, 2'h0);
		fork
			go(32'h3);
			begin
				repeat (20) @(posedge clk);
				trig <= 1'b1;
				repeat (40) @(posedge clk);
				chk("trig_rise", 32'h0, 32'(target_halt));
				trig <= 1'b0;
			end
		join
		test_done();
	end
endmodule : tb_ebt_top
`default_nettype wire
